// ==== logic/ppm_cfg.svh ====
`ifndef PPM_CFG_SVH
`define PPM_CFG_SVH

// ----------------------------------------------------------------
// pointer register file offsets and reset
// ----------------------------------------------------------------
`define PPM_OFS_PTR_LOW    12'hFF6
`define PPM_OFS_PTR_HIGH   12'hFF7
`define PPM_OFS_PTR_UPPER  12'hFF8
`define PPM_PTR_RST        22'h000000
`define PPM_UPPER_PAD      2'h0
`define PPM_STEP_TWO       22'h000002
`define PPM_ZERO_BYTE      8'h00
`define PPM_WR_DATA_RST    16'h0000

// ----------------------------------------------------------------
// address map (byte addresses, upper bounds exclusive for code)
// ----------------------------------------------------------------
`define PPM_CODE_SPACE_END 22'h200000
`define PPM_LIM_64K        22'h010000
`define PPM_LIM_48K        22'h00C000
`define PPM_LIM_32K        22'h008000
`define PPM_LIM_24K        22'h006000
`define PPM_BOOT_1KW       22'h000800
`define PPM_BOOT_2KW       22'h001000
`define PPM_BOOT_4KW       22'h002000
`define PPM_ID_FIRST       22'h200000
`define PPM_ID_LAST        22'h200007
`define PPM_CFG_FIRST      22'h300000
`define PPM_CFG_LAST       22'h30000D
`define PPM_DEVID_FIRST    22'h3FFFFE
`define PPM_DEVID_LAST     22'h3FFFFF

// ----------------------------------------------------------------
// boot size field codes and serial command codes
// ----------------------------------------------------------------
`define PPM_BOOT_SEL_1KW   2'h0
`define PPM_BOOT_SEL_2KW   2'h1
`define PPM_CMD_CORE       4'h0
`define PPM_CMD_WRITE2     4'hD
`define PPM_CMD_WRITE_GO   4'hF

`endif

// ==== logic/ppm_map_decode.sv ====
`include "ppm_cfg.svh"

module ppm_map_decode (
    input  wire logic [21:0]          i_addr,
    input  wire ppm_pkg::ppm_variant_t i_variant,
    input  wire logic                 i_boot_cfg_en,
    input  wire logic [1:0]           i_boot_region_size_field,
    output ppm_pkg::ppm_decode_t      o_dec
);
    import ppm_pkg::*;

    // ------------------------------------------------------------
    // code size and boot size selection
    // ------------------------------------------------------------
    wire logic        is_large;
    wire logic [21:0] code_limit;
    wire logic [21:0] boot_limit;
    wire logic [1:0]  blk_idx;

    assign is_large   = (i_variant == ppm_var_large4) || (i_variant == ppm_var_large3);
    assign code_limit = (i_variant == ppm_var_large4) ? `PPM_LIM_64K :
                        (i_variant == ppm_var_large3) ? `PPM_LIM_48K :
                        (i_variant == ppm_var_small4) ? `PPM_LIM_32K : `PPM_LIM_24K;
    assign boot_limit = (!i_boot_cfg_en) ? `PPM_BOOT_1KW :
                        (i_boot_region_size_field == `PPM_BOOT_SEL_1KW) ? `PPM_BOOT_1KW :
                        (i_boot_region_size_field == `PPM_BOOT_SEL_2KW) ? `PPM_BOOT_2KW :
                        `PPM_BOOT_4KW;
    assign blk_idx    = is_large ? i_addr[15:14] : i_addr[14:13];

    // ------------------------------------------------------------
    // region decode
    // ------------------------------------------------------------
    wire logic in_boot;
    wire logic in_code;
    wire logic in_id;
    wire logic in_cfg;
    wire logic in_devid;

    assign in_boot  = i_addr < boot_limit;
    assign in_code  = (i_addr < code_limit) && !in_boot;
    assign in_id    = (i_addr >= `PPM_ID_FIRST) && (i_addr <= `PPM_ID_LAST);
    assign in_cfg   = (i_addr >= `PPM_CFG_FIRST) && (i_addr <= `PPM_CFG_LAST);
    assign in_devid = (i_addr >= `PPM_DEVID_FIRST) && (i_addr <= `PPM_DEVID_LAST);

    assign o_dec.region = in_boot  ? ppm_rgn_boot  :
                          in_code  ? ppm_rgn_code  :
                          in_id    ? ppm_rgn_id    :
                          in_cfg   ? ppm_rgn_cfg   :
                          in_devid ? ppm_rgn_devid : ppm_rgn_unimpl;
    assign o_dec.block  = in_code ? blk_idx : 2'h0;

endmodule : ppm_map_decode

// ==== logic/ppm_pkg.sv ====
package ppm_pkg;

    // ------------------------------------------------------------
    // region, variant and carrier types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ppm_rgn_boot   = 3'h0,
        ppm_rgn_code   = 3'h1,
        ppm_rgn_id     = 3'h2,
        ppm_rgn_cfg    = 3'h3,
        ppm_rgn_devid  = 3'h4,
        ppm_rgn_unimpl = 3'h5
    } ppm_region_t;

    typedef enum logic [1:0] {
        ppm_var_large4 = 2'h0,
        ppm_var_large3 = 2'h1,
        ppm_var_small4 = 2'h2,
        ppm_var_small3 = 2'h3
    } ppm_variant_t;

    typedef struct packed {
        logic        valid;
        logic [3:0]  code;
        logic [15:0] data;
    } ppm_cmd_t;

    typedef struct packed {
        ppm_region_t region;
        logic [1:0]  block;
    } ppm_decode_t;

endpackage : ppm_pkg

// ==== logic/ppm_ptr_map.sv ====
`include "ppm_cfg.svh"

module ppm_ptr_map (
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_rst_n,
    input  wire logic [11:0]           i_reg_addr,
    input  wire logic                  i_reg_wr,
    input  wire logic [7:0]            i_reg_wdata,
    output logic [7:0]                 o_reg_rdata,
    input  wire ppm_pkg::ppm_cmd_t     i_cmd,
    input  wire logic                  i_rd_req,
    input  wire ppm_pkg::ppm_variant_t i_variant,
    input  wire logic                  i_boot_cfg_en,
    input  wire logic [1:0]            i_boot_region_size_field,
    input  wire logic [4:0]            i_protect_mask,
    output logic [21:0]                o_mem_addr,
    output ppm_pkg::ppm_region_t       o_mem_region,
    output logic [1:0]                 o_mem_block,
    input  wire logic [7:0]            i_mem_rdata,
    output logic [7:0]                 o_rd_data,
    output logic                       o_rd_valid,
    output logic                       o_mem_wr,
    output logic                       o_prog_start,
    output logic [21:0]                o_wr_addr,
    output logic [15:0]                o_wr_data
);
    import ppm_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [21:0] ptr_reg;
    logic [21:0] ptr_next;
    logic [7:0]  reg_rdata_reg;
    logic [7:0]  reg_rdata_next;
    logic [7:0]  rd_data_reg;
    logic [7:0]  rd_data_next;
    logic        rd_valid_reg;
    logic        mem_wr_reg;
    logic        prog_start_reg;
    logic [21:0] wr_addr_reg;
    logic [21:0] wr_addr_next;
    logic [15:0] wr_data_reg;
    logic [15:0] wr_data_next;
    ppm_decode_t dec;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    ppm_map_decode u_decode (
        .i_addr                   (ptr_reg),
        .i_variant                (i_variant),
        .i_boot_cfg_en            (i_boot_cfg_en),
        .i_boot_region_size_field (i_boot_region_size_field),
        .o_dec                    (dec)
    );

    // ------------------------------------------------------------
    // pointer register file
    // ------------------------------------------------------------
    wire logic wr_low;
    wire logic wr_high;
    wire logic wr_upper;
    wire logic cmd_write2;
    wire logic cmd_write_go;
    wire logic wr_allowed;

    assign wr_low       = i_reg_wr && (i_reg_addr == `PPM_OFS_PTR_LOW);
    assign wr_high      = i_reg_wr && (i_reg_addr == `PPM_OFS_PTR_HIGH);
    assign wr_upper     = i_reg_wr && (i_reg_addr == `PPM_OFS_PTR_UPPER);
    assign cmd_write2   = i_cmd.valid && (i_cmd.code == `PPM_CMD_WRITE2);
    assign cmd_write_go = i_cmd.valid && (i_cmd.code == `PPM_CMD_WRITE_GO);
    // table writes reach id and config too
    assign wr_allowed   = dec.region != ppm_rgn_unimpl;

    assign ptr_next = wr_upper ? {i_reg_wdata[5:0], ptr_reg[15:0]} :
                      wr_high  ? {ptr_reg[21:16], i_reg_wdata, ptr_reg[7:0]} :
                      wr_low   ? {ptr_reg[21:8], i_reg_wdata} :
                      cmd_write2 ? ptr_reg + `PPM_STEP_TWO : ptr_reg;

    // register readback, upper pad reads zero
    assign reg_rdata_next = (i_reg_addr == `PPM_OFS_PTR_LOW)   ? ptr_reg[7:0]  :
                            (i_reg_addr == `PPM_OFS_PTR_HIGH)  ? ptr_reg[15:8] :
                            (i_reg_addr == `PPM_OFS_PTR_UPPER) ?
                                {`PPM_UPPER_PAD, ptr_reg[21:16]} : `PPM_ZERO_BYTE;

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    wire logic [3:0] blk_prot;
    wire logic       prot_hit;
    wire logic       read_zero;

    assign blk_prot  = i_protect_mask[4:1];
    assign prot_hit  = ((dec.region == ppm_rgn_boot) && i_protect_mask[0]) ||
                       ((dec.region == ppm_rgn_code) && blk_prot[dec.block]);
    // id, config, device id never masked; unimplemented zero
    assign read_zero = prot_hit || (dec.region == ppm_rgn_unimpl);
    assign rd_data_next = i_rd_req ? (read_zero ? `PPM_ZERO_BYTE : i_mem_rdata)
                                   : rd_data_reg;

    assign wr_addr_next = (cmd_write2 || cmd_write_go) ? ptr_reg : wr_addr_reg;
    assign wr_data_next = (cmd_write2 || cmd_write_go) ? i_cmd.data : wr_data_reg;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // pointer and readback
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            ptr_reg       <= `PPM_PTR_RST;
            reg_rdata_reg <= `PPM_ZERO_BYTE;
        end else begin
            ptr_reg       <= ptr_next;
            reg_rdata_reg <= reg_rdata_next;
        end
    end

    // read answer and write strobe
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            rd_data_reg    <= `PPM_ZERO_BYTE;
            rd_valid_reg   <= 1'b0;
            mem_wr_reg     <= 1'b0;
            prog_start_reg <= 1'b0;
            wr_addr_reg    <= `PPM_PTR_RST;
            wr_data_reg    <= `PPM_WR_DATA_RST;
        end else begin
            rd_data_reg    <= rd_data_next;
            rd_valid_reg   <= i_rd_req;
            mem_wr_reg     <= (cmd_write2 || cmd_write_go) && wr_allowed;
            prog_start_reg <= cmd_write_go && wr_allowed;
            wr_addr_reg    <= wr_addr_next;
            wr_data_reg    <= wr_data_next;
        end
    end

    assign o_reg_rdata  = reg_rdata_reg;
    assign o_mem_addr   = ptr_reg;
    assign o_mem_region = dec.region;
    assign o_mem_block  = dec.block;
    assign o_rd_data    = rd_data_reg;
    assign o_rd_valid   = rd_valid_reg;
    assign o_mem_wr     = mem_wr_reg;
    assign o_prog_start = prog_start_reg;
    assign o_wr_addr    = wr_addr_reg;
    assign o_wr_data    = wr_data_reg;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    property p_ptr_adv_two;
        cmd_write2 && !i_reg_wr |=> ptr_reg == $past(ptr_reg) + `PPM_STEP_TWO;
    endproperty
    a_ptr_adv_two: assert property (p_ptr_adv_two)
        else $error("pointer did not advance by two");

    property p_write_strobe;
        cmd_write2 && wr_allowed |=> o_mem_wr && !o_prog_start
            && (o_wr_addr == $past(ptr_reg)) && (o_wr_data == $past(i_cmd.data));
    endproperty
    a_write_strobe: assert property (p_write_strobe)
        else $error("write two bytes not stored at pointer");

    property p_id_readable;
        i_rd_req && (dec.region == ppm_rgn_id) |=> o_rd_valid
            && (o_rd_data == $past(i_mem_rdata));
    endproperty
    a_id_readable: assert property (p_id_readable)
        else $error("id byte masked");

    property p_cfg_readable;
        i_rd_req && (dec.region == ppm_rgn_cfg) |=> o_rd_data == $past(i_mem_rdata);
    endproperty
    a_cfg_readable: assert property (p_cfg_readable)
        else $error("config byte masked");

    property p_devid_readable;
        i_rd_req && (ptr_reg == `PPM_DEVID_LAST) |=> o_rd_data == $past(i_mem_rdata);
    endproperty
    a_devid_readable: assert property (p_devid_readable)
        else $error("device id masked");

    // independent code size choice for the unimplemented check
    wire logic [21:0] code_limit_chk;
    assign code_limit_chk = (i_variant == ppm_var_large4) ? `PPM_LIM_64K :
                            (i_variant == ppm_var_large3) ? `PPM_LIM_48K :
                            (i_variant == ppm_var_small4) ? `PPM_LIM_32K : `PPM_LIM_24K;

    property p_unimpl_zero;
        i_rd_req && (ptr_reg >= code_limit_chk) && (ptr_reg < `PPM_CODE_SPACE_END)
            |=> o_rd_data == `PPM_ZERO_BYTE;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero)
        else $error("unimplemented code not zero");

    // low byte lands, upper two bytes kept; register write beats increment
    property p_ptr_load;
        wr_low |=> (ptr_reg[7:0] == $past(i_reg_wdata))
            && (ptr_reg[21:8] == $past(ptr_reg[21:8]));
    endproperty
    a_ptr_load: assert property (p_ptr_load)
        else $error("low pointer byte not loaded");

    property p_upper_six;
        wr_upper |=> ptr_reg[21:16] == $past(i_reg_wdata[5:0]);
    endproperty
    a_upper_six: assert property (p_upper_six)
        else $error("upper pointer bits wrong");

    property p_boot_first;
        (ptr_reg < `PPM_BOOT_1KW) |-> dec.region == ppm_rgn_boot;
    endproperty
    a_boot_first: assert property (p_boot_first)
        else $error("lowest code not in boot region");

    property p_boot_big;
        i_boot_cfg_en && i_boot_region_size_field[1] && (ptr_reg < `PPM_BOOT_4KW)
            |-> dec.region == ppm_rgn_boot;
    endproperty
    a_boot_big: assert property (p_boot_big)
        else $error("enlarged boot region not honoured");

    property p_large_block;
        (i_variant == ppm_var_large4) && (dec.region == ppm_rgn_code)
            |-> dec.block == ptr_reg[15:14];
    endproperty
    a_large_block: assert property (p_large_block)
        else $error("large block index wrong");

    property p_small_end;
        (i_variant == ppm_var_small3) && (ptr_reg >= `PPM_LIM_24K)
            && (ptr_reg < `PPM_CODE_SPACE_END) |-> dec.region == ppm_rgn_unimpl;
    endproperty
    a_small_end: assert property (p_small_end)
        else $error("small part decodes past 24K");

    property p_protect_zero;
        i_rd_req && (dec.region == ppm_rgn_boot) && i_protect_mask[0]
            |=> o_rd_data == `PPM_ZERO_BYTE;
    endproperty
    a_protect_zero: assert property (p_protect_zero)
        else $error("protected boot read not zero");

    c_write2:   cover property (cmd_write2 ##1 o_mem_wr);
    c_write_go: cover property (cmd_write_go ##1 o_prog_start);
    c_id_read:  cover property (i_rd_req && (dec.region == ppm_rgn_id));
    c_prot:     cover property (i_rd_req && prot_hit);

endmodule : ppm_ptr_map

// ==== verif/ppm_mem_model.sv ====
module ppm_mem_model (
    input  wire logic [21:0] i_addr,
    output logic      [7:0]  o_rdata
);
    timeunit 1ns;
    timeprecision 100ps;

    // every location holds a byte
    // answer mixes all three address bytes so neighbours that share the upper two bytes differ
    assign o_rdata = i_addr[7:0] ^ i_addr[15:8] ^ {2'h0, i_addr[21:16]} ^ 8'h5A;
endmodule : ppm_mem_model

// ==== verif/ppm_ptr_map_tb_top.sv ====
module ppm_ptr_map_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import ppm_pkg::*;

    // ------------------------------------------------------------
    // bench signals
    // ------------------------------------------------------------
    logic         clk_sys, rst_n, reg_wr, rd_req, boot_en, rd_valid, mem_wr, prog_start;
    logic [11:0]  reg_addr;
    logic [7:0]   reg_wdata, reg_rdata, mem_rdata, rd_data;
    logic [1:0]   boot_fld, mem_block;
    logic [4:0]   prot;
    logic [21:0]  mem_addr, wr_addr;
    logic [15:0]  wr_data;
    ppm_cmd_t     cmd;
    ppm_variant_t variant;
    ppm_region_t  mem_region;
    int           num_errors, tests_run;

    // free running system clock
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    ppm_ptr_map i_ppm_ptr_map (
        .i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_reg_addr(reg_addr), .i_reg_wr(reg_wr),
        .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata), .i_cmd(cmd), .i_rd_req(rd_req),
        .i_variant(variant), .i_boot_cfg_en(boot_en), .i_boot_region_size_field(boot_fld),
        .i_protect_mask(prot), .o_mem_addr(mem_addr), .o_mem_region(mem_region),
        .o_mem_block(mem_block), .i_mem_rdata(mem_rdata), .o_rd_data(rd_data),
        .o_rd_valid(rd_valid), .o_mem_wr(mem_wr), .o_prog_start(prog_start),
        .o_wr_addr(wr_addr), .o_wr_data(wr_data)
    );

    ppm_mem_model i_ppm_mem_model (.i_addr(mem_addr), .o_rdata(mem_rdata));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic finish_test;
        $display("tests_run=%0d num_errors=%0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %0t %s got %0h exp %0h", $time, msg, got, exp);
        end
    endtask : chk

    function automatic logic [7:0] pat(input logic [21:0] a);
        return a[7:0] ^ a[15:8] ^ {2'h0, a[21:16]} ^ 8'h5A;
    endfunction : pat

    task automatic wreg(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wr    <= 1'b1;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wreg

    task automatic rreg(input logic [11:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        @(posedge clk_sys);
        #1;
        chk(reg_rdata, exp, "register readback");
    endtask : rreg

    task automatic set_ptr(input logic [21:0] p);
        wreg(12'hFF8, {2'h0, p[21:16]});
        wreg(12'hFF7, p[15:8]);
        wreg(12'hFF6, p[7:0]);
        #1;
        chk(mem_addr, p, "pointer load");
    endtask : set_ptr

    task automatic cfg(input logic [1:0] v, input logic en, input logic [1:0] f,
                       input logic [4:0] m);
        @(posedge clk_sys);
        variant  <= ppm_variant_t'(v);
        boot_en  <= en;
        boot_fld <= f;
        prot     <= m;
    endtask : cfg

    task automatic rchk(input logic [21:0] a, input ppm_region_t r, input logic [1:0] b,
                        input logic on);
        set_ptr(a);
        chk(mem_region, r, "region");
        chk(mem_block, b, "block");
        @(posedge clk_sys);
        rd_req <= 1'b1;
        @(posedge clk_sys);
        rd_req <= 1'b0;
        #1;
        chk(rd_valid, 1'b1, "read valid");
        chk(rd_data, on ? pat(a) : 8'h00, "read data");
        @(posedge clk_sys);
        #1;
        chk(rd_valid, 1'b0, "read valid pulse");
    endtask : rchk

    task automatic wcmd(input logic [3:0] c, input logic [15:0] d, input logic w,
                        input logic [21:0] np);
        logic [21:0] p;
        p = mem_addr;
        @(posedge clk_sys);
        cmd <= '{1'b1, c, d};
        @(posedge clk_sys);
        cmd <= '{1'b0, 4'h0, 16'h0000};
        #1;
        chk(mem_wr, w, "write strobe");
        chk(prog_start, w & (c == 4'hF), "program start");
        chk(wr_addr, p, "write address");
        chk(wr_data, d, "write data");
        chk(mem_addr, np, "pointer after write");
    endtask : wcmd

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        set_ptr(22'h2A5C3E);
        rreg(12'hFF8, 8'h2A);
        rreg(12'hFF7, 8'h5C);
        rreg(12'hFF6, 8'h3E);
        rreg(12'hFF9, 8'h00);
        wreg(12'hFF8, 8'hFF);
        #1 chk(mem_addr, 22'h3F5C3E, "upper bits dropped");
        wreg(12'hFF5, 8'h11);
        #1 chk(mem_addr, 22'h3F5C3E, "unmapped write");
        $display("test regs done");
    endtask : t_regs

    task automatic t_map;
        cfg(2'h0, 1'b0, 2'h0, 5'h00);
        rchk(22'h0007FF, ppm_rgn_boot, 2'h0, 1'b1);
        rchk(22'h000800, ppm_rgn_code, 2'h0, 1'b1);
        rchk(22'h004000, ppm_rgn_code, 2'h1, 1'b1);
        rchk(22'h00FFFF, ppm_rgn_code, 2'h3, 1'b1);
        rchk(22'h010000, ppm_rgn_unimpl, 2'h0, 1'b0);
        cfg(2'h1, 1'b0, 2'h0, 5'h00);
        rchk(22'h00BFFF, ppm_rgn_code, 2'h2, 1'b1);
        rchk(22'h00C000, ppm_rgn_unimpl, 2'h0, 1'b0);
        cfg(2'h2, 1'b0, 2'h0, 5'h00);
        rchk(22'h002000, ppm_rgn_code, 2'h1, 1'b1);
        rchk(22'h007FFF, ppm_rgn_code, 2'h3, 1'b1);
        rchk(22'h008000, ppm_rgn_unimpl, 2'h0, 1'b0);
        cfg(2'h3, 1'b0, 2'h0, 5'h00);
        rchk(22'h005FFF, ppm_rgn_code, 2'h2, 1'b1);
        rchk(22'h006000, ppm_rgn_unimpl, 2'h0, 1'b0);
        $display("test map done");
    endtask : t_map

    task automatic t_boot;
        cfg(2'h0, 1'b1, 2'h1, 5'h00);
        rchk(22'h000FFF, ppm_rgn_boot, 2'h0, 1'b1);
        rchk(22'h001000, ppm_rgn_code, 2'h0, 1'b1);
        cfg(2'h0, 1'b1, 2'h2, 5'h00);
        rchk(22'h001FFF, ppm_rgn_boot, 2'h0, 1'b1);
        rchk(22'h002000, ppm_rgn_code, 2'h0, 1'b1);
        cfg(2'h0, 1'b1, 2'h3, 5'h00);
        rchk(22'h001FFF, ppm_rgn_boot, 2'h0, 1'b1);
        cfg(2'h0, 1'b1, 2'h0, 5'h00);
        rchk(22'h000800, ppm_rgn_code, 2'h0, 1'b1);
        cfg(2'h0, 1'b0, 2'h2, 5'h00);
        rchk(22'h000800, ppm_rgn_code, 2'h0, 1'b1);
        $display("test boot done");
    endtask : t_boot

    task automatic t_protect;
        cfg(2'h0, 1'b0, 2'h0, 5'h01);
        rchk(22'h0007FE, ppm_rgn_boot, 2'h0, 1'b0);
        rchk(22'h000800, ppm_rgn_code, 2'h0, 1'b1);
        cfg(2'h0, 1'b0, 2'h0, 5'h04);
        rchk(22'h004000, ppm_rgn_code, 2'h1, 1'b0);
        rchk(22'h003FFF, ppm_rgn_code, 2'h0, 1'b1);
        cfg(2'h0, 1'b0, 2'h0, 5'h1F);
        rchk(22'h008000, ppm_rgn_code, 2'h2, 1'b0);
        rchk(22'h200000, ppm_rgn_id, 2'h0, 1'b1);
        rchk(22'h200007, ppm_rgn_id, 2'h0, 1'b1);
        rchk(22'h300000, ppm_rgn_cfg, 2'h0, 1'b1);
        rchk(22'h30000D, ppm_rgn_cfg, 2'h0, 1'b1);
        rchk(22'h3FFFFE, ppm_rgn_devid, 2'h0, 1'b1);
        rchk(22'h3FFFFF, ppm_rgn_devid, 2'h0, 1'b1);
        $display("test protect done");
    endtask : t_protect

    task automatic t_write;
        cfg(2'h0, 1'b0, 2'h0, 5'h00);
        set_ptr(22'h000100);
        wcmd(4'hD, 16'hABCD, 1'b1, 22'h000102);
        wcmd(4'hF, 16'h1234, 1'b1, 22'h000102);
        set_ptr(22'h200000);
        @(posedge clk_sys);
        cmd <= '{1'b1, 4'hD, 16'h1111};
        @(posedge clk_sys);
        cmd <= '{1'b1, 4'hD, 16'h2222};
        @(posedge clk_sys);
        cmd <= '{1'b0, 4'h0, 16'h0000};
        #1;
        chk({mem_wr, mem_addr}, {1'b1, 22'h200004}, "back to back pointer");
        chk(wr_addr, 22'h200002, "back to back address");
        chk(wr_data, 16'h2222, "back to back data");
        cfg(2'h1, 1'b0, 2'h0, 5'h00);
        set_ptr(22'h00C000);
        wcmd(4'hD, 16'h0F0F, 1'b0, 22'h00C002);
        $display("test write done");
    endtask : t_write

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        num_errors = 0;
        tests_run  = 0;
        rst_n      = 1'b0;
        reg_addr   = 12'h000;
        reg_wr     = 1'b0;
        reg_wdata  = 8'h00;
        cmd        = '{1'b0, 4'h0, 16'h0000};
        rd_req     = 1'b0;
        variant    = ppm_var_large4;
        boot_en    = 1'b0;
        boot_fld   = 2'h0;
        prot       = 5'h00;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        #1;
        chk({mem_addr, mem_wr, rd_valid}, 24'h000000, "reset state");
        chk(mem_region, ppm_rgn_boot, "reset region");
        t_regs();
        t_map();
        t_boot();
        t_protect();
        t_write();
        finish_test();
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        $display("FAIL %0t run did not complete in time", $time);
        finish_test();
    end
endmodule : ppm_ptr_map_tb_top
